/* hw/fspc_ctrl.sv */
// Purpose: flash program memory self-program controller
// Assumes: special function register strobes and programmer port on the core clock
// Notes:   por_n clears the write error flag; rst_n is any device reset
// How it works
// - data pair 14 bits, address pair 15 bits
// - high address byte, low address byte form address
// - internal timer sets write and erase duration
// - code protect blocks programmer, not self-write
// - only programmer bulk erase removes code protect
// - write protect field refuses self write, erase
// - start bits set-only, hardware clears on completion
// - self writes need write enable; cleared at power-up
// - reset during write sets write error flag
// - unlock register reads as zero
// - self writes change latches and memory only after unlock
// - erase clears one whole row
// - data pair loads hidden fourteen-bit write latches
// - self-programming only clears bits, erase needed to set them
`timescale 1ns/1ps

module fspc_ctrl
    import fspc_pkg::*;
(
    // clock and resets
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             por_n,
    input  wire logic             ce,
    // special function register access
    input  wire fspc_sel_e        sfr_sel,
    input  wire logic             sfr_wr,
    input  wire logic             sfr_rd,
    input  wire logic [7:0]       sfr_wdata,
    output logic      [7:0]       sfr_rdata,
    // configuration and status
    output logic                  code_protect_bit,
    output logic      [1:0]       write_protect_field,
    output logic                  busy,
    // external programmer
    input  wire logic             ext_rd,
    input  wire logic             ext_wr,
    input  wire logic             ext_cfg_wr,
    input  wire logic             ext_id_wr,
    input  wire logic             ext_bulk_erase,
    input  wire fspc_addr_t       ext_addr,
    input  wire fspc_word_t       ext_wdata,
    input  wire logic             ext_cfg_cp,
    input  wire logic [1:0]       ext_cfg_wrt,
    output fspc_word_t            ext_rdata,
    output logic                  ext_denied
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    fspc_word_t                   mem [`FSPC_MEM_WORDS];
    fspc_word_t                   latch [`FSPC_ROW_WORDS];
    fspc_word_t                   user_id [4];
    fspc_addr_t                   addr;
    fspc_word_t                   data_word;
    logic                         rd_bit;
    logic                         wr_bit;
    logic                         write_enable_bit;
    logic                         write_error_flag;
    logic                         erase_sel;
    logic                         latch_only;
    logic                         write_mark;
    logic       [1:0]             rst_sync;
    logic       [`FSPC_TIMER_W-1:0] timer;
    fspc_unlock_e                 ul_state;
    fspc_op_e                     op_state;

    logic                         ctrl_wr;
    logic                         start_req;
    logic                         is_protected;
    logic                         launch;
    logic                         timed;
    logic                         op_done;
    fspc_addr_t                   row_base;
    fspc_word_t                   rd_word;

    assign ctrl_wr   = sfr_wr && (sfr_sel == FSPC_SEL_CONTROL);
    assign start_req = ctrl_wr && sfr_wdata[`FSPC_CTRL_WR] && !wr_bit;
    assign row_base  = {addr[`FSPC_ADDR_W-1:`FSPC_ROW_BITS], `FSPC_ROW_BITS'h0};
    assign rd_word   = mem[addr];
    assign timed     = (op_state == OP_ERASE) || (op_state == OP_PROGRAM);
    assign op_done   = (op_state == OP_LATCH)
                    || (timed && timer == `FSPC_TIMER_W'(`FSPC_WRITE_CYCLES - 1));
    assign busy      = wr_bit;

    always_comb
    begin
        case (write_protect_field)
            `FSPC_WRT_OFF:  is_protected = 1'b0;
            `FSPC_WRT_LOW:  is_protected = addr < `FSPC_WRT_LOW_LIMIT;
            `FSPC_WRT_HALF: is_protected = addr < `FSPC_WRT_HALF_LIMIT;
            default:        is_protected = 1'b1;
        endcase
    end

    // keys, then write enable, then an unprotected address
    assign launch = start_req && (ul_state == UL_KEY2)
                 && write_enable_bit && !is_protected;

    // ----------------------------------------------------------------
    // unlock sequence
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            ul_state <= UL_IDLE;
        else if (ce)
        begin
            if (sfr_wr && sfr_sel == FSPC_SEL_UNLOCK)
            begin
                case (ul_state)
                    UL_IDLE: ul_state <= (sfr_wdata == `FSPC_KEY1) ? UL_KEY1 : UL_IDLE;
                    UL_KEY1: ul_state <= (sfr_wdata == `FSPC_KEY2) ? UL_KEY2 : UL_IDLE;
                    default: ul_state <= UL_IDLE;
                endcase
            end
            else if (sfr_wr || sfr_rd)
                ul_state <= UL_IDLE;
        end
    end

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_bit           <= 1'b0;
            wr_bit           <= 1'b0;
            write_enable_bit <= 1'b0;
            erase_sel        <= 1'b0;
            latch_only       <= 1'b0;
        end
        else if (ce)
        begin
            if (ctrl_wr)
            begin
                write_enable_bit <= sfr_wdata[`FSPC_CTRL_WRITE_ENABLE_BIT];
                if (!wr_bit)
                begin
                    erase_sel  <= sfr_wdata[`FSPC_CTRL_ERASE];
                    latch_only <= sfr_wdata[`FSPC_CTRL_LATCH];
                end
            end
            // software only sets; hardware clears at completion
            if (ctrl_wr && sfr_wdata[`FSPC_CTRL_RD] && !wr_bit)
                rd_bit <= 1'b1;
            else if (rd_bit)
                rd_bit <= 1'b0;
            if (launch)
                wr_bit <= 1'b1;
            else if (op_done)
                wr_bit <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // operation sequencer and timer
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            op_state <= OP_IDLE;
            timer    <= '0;
        end
        else if (ce)
        begin
            case (op_state)
                OP_IDLE:
                begin
                    timer <= '0;
                    if (launch && sfr_wdata[`FSPC_CTRL_ERASE])
                        op_state <= OP_ERASE;
                    else if (launch && sfr_wdata[`FSPC_CTRL_LATCH])
                        op_state <= OP_LATCH;
                    else if (launch)
                        op_state <= OP_PROGRAM;
                end
                OP_LATCH:
                    op_state <= OP_IDLE;
                OP_ERASE, OP_PROGRAM:
                begin
                    timer <= timer + `FSPC_TIMER_W'(1);
                    if (op_done)
                        op_state <= OP_IDLE;
                end
                default:
                    op_state <= OP_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // address and data pairs
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr      <= '0;
            data_word <= '0;
        end
        else if (ce)
        begin
            if (sfr_wr && sfr_sel == FSPC_SEL_ADDR_LOW)
                addr[7:0] <= sfr_wdata;
            if (sfr_wr && sfr_sel == FSPC_SEL_ADDR_HIGH)
                addr[`FSPC_ADDR_W-1:8] <= sfr_wdata[`FSPC_ADDR_W-9:0];
            if (rd_bit)
                data_word <= rd_word;
            else
            begin
                if (sfr_wr && sfr_sel == FSPC_SEL_DATA_LOW)
                    data_word[7:0] <= sfr_wdata;
                if (sfr_wr && sfr_sel == FSPC_SEL_DATA_HIGH)
                    data_word[`FSPC_DATA_W-1:8] <= sfr_wdata[`FSPC_DATA_W-9:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // register read port
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            sfr_rdata <= 8'h00;
        else if (ce && sfr_rd)
        begin
            case (sfr_sel)
                FSPC_SEL_ADDR_LOW:  sfr_rdata <= addr[7:0];
                FSPC_SEL_ADDR_HIGH: sfr_rdata <= {1'b0, addr[`FSPC_ADDR_W-1:8]};
                FSPC_SEL_DATA_LOW:  sfr_rdata <= data_word[7:0];
                FSPC_SEL_DATA_HIGH: sfr_rdata <= {2'b00, data_word[`FSPC_DATA_W-1:8]};
                FSPC_SEL_CONTROL:   sfr_rdata <= {2'b00, latch_only, erase_sel,
                                                  write_error_flag, write_enable_bit,
                                                  wr_bit, rd_bit};
                default:            sfr_rdata <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // write error tracking across resets
    // ----------------------------------------------------------------
    // mark survives rst_n; only completion, transfer or por_n clears it
    always_ff @(posedge clock or negedge por_n)
    begin
        if (!por_n)
        begin
            rst_sync         <= 2'b11;
            write_mark       <= 1'b0;
            write_error_flag <= 1'b0;
        end
        else if (ce)
        begin
            rst_sync <= {rst_sync[0], rst_n};
            if (!rst_sync[1] && write_mark)
            begin
                write_mark       <= 1'b0;
                write_error_flag <= 1'b1;
            end
            else
            begin
                if (launch && !sfr_wdata[`FSPC_CTRL_LATCH])
                    write_mark <= 1'b1;
                else if (timed && op_done)
                    write_mark <= 1'b0;
                if (ctrl_wr && !sfr_wdata[`FSPC_CTRL_WRITE_ERROR_FLAG])
                    write_error_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // configuration and programmer port
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (ce)
        begin
            if (ext_bulk_erase)
            begin
                code_protect_bit    <= 1'b1;
                write_protect_field <= `FSPC_WRT_OFF;
                for (int i = 0; i < 4; i++)
                    user_id[i] <= `FSPC_ERASED_WORD;
            end
            else
            begin
                if (ext_cfg_wr)
                begin
                    code_protect_bit    <= code_protect_bit & ext_cfg_cp;
                    write_protect_field <= ext_cfg_wrt;
                end
                if (ext_id_wr && code_protect_bit)
                    user_id[ext_addr[1:0]] <= ext_wdata;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_rdata  <= '0;
            ext_denied <= 1'b0;
        end
        else if (ce)
        begin
            ext_denied <= (ext_rd || ext_wr) && !code_protect_bit;
            if (ext_rd)
                ext_rdata <= code_protect_bit ? mem[ext_addr] : '0;
        end
    end

    // ----------------------------------------------------------------
    // write latches and program memory
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (ce)
        begin
            if (ext_bulk_erase)
            begin
                for (int i = 0; i < `FSPC_MEM_WORDS; i++)
                    mem[i] <= `FSPC_ERASED_WORD;
            end
            else if (ext_wr && code_protect_bit)
                mem[ext_addr] <= ext_wdata;
            else if (op_state == OP_ERASE && op_done)
            begin
                for (int i = 0; i < `FSPC_ROW_WORDS; i++)
                    mem[row_base + `FSPC_ADDR_W'(i)] <= `FSPC_ERASED_WORD;
            end
            else if (op_state == OP_PROGRAM && op_done)
            begin
                for (int i = 0; i < `FSPC_ROW_WORDS; i++)
                    mem[row_base + `FSPC_ADDR_W'(i)] <=
                        mem[row_base + `FSPC_ADDR_W'(i)] & latch[i];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < `FSPC_ROW_WORDS; i++)
                latch[i] <= `FSPC_ERASED_WORD;
        end
        else if (ce)
        begin
            if (launch && !sfr_wdata[`FSPC_CTRL_ERASE])
                latch[addr[`FSPC_ROW_BITS-1:0]] <= data_word;
            else if (op_state == OP_PROGRAM && op_done)
            begin
                for (int i = 0; i < `FSPC_ROW_WORDS; i++)
                    latch[i] <= `FSPC_ERASED_WORD;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [`FSPC_TIMER_W-1:0] timed_len;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            timed_len <= '0;
        else if (ce)
            timed_len <= timed ? timed_len + `FSPC_TIMER_W'(1) : '0;
    end

    property p_unlock;
        @(posedge clock) disable iff (!rst_n) $rose(wr_bit) |-> $past(ul_state) == UL_KEY2;
    endproperty
    a_unlock: assert property (p_unlock) else $error("write started without unlock keys");
    property p_write_enable_bit;
        @(posedge clock) disable iff (!rst_n) $rose(wr_bit) |-> $past(write_enable_bit);
    endproperty
    a_write_enable_bit: assert property (p_write_enable_bit) else $error("write started without write enable");
    property p_wrt;
        @(posedge clock) disable iff (!rst_n) $rose(wr_bit) |-> !$past(is_protected);
    endproperty
    a_wrt: assert property (p_wrt) else $error("write started in protected region");
    property p_read;
        @(posedge clock) disable iff (!rst_n)
            (ce && rd_bit) |=> (!rd_bit && data_word == $past(rd_word));
    endproperty
    a_read: assert property (p_read) else $error("read did not load data pair");
    property p_timer;
        @(posedge clock) disable iff (!rst_n)
            (ce && timed && !op_done) |=> (timed && wr_bit);
    endproperty
    a_timer: assert property (p_timer) else $error("timed operation ended early");
    property p_len;
        @(posedge clock) disable iff (!rst_n)
            $fell(timed) |-> timed_len == `FSPC_TIMER_W'(`FSPC_WRITE_CYCLES);
    endproperty
    a_len: assert property (p_len) else $error("timed operation length wrong");
    property p_unlock_rd;
        @(posedge clock) disable iff (!rst_n)
            (ce && sfr_rd && sfr_sel == FSPC_SEL_UNLOCK) |=> sfr_rdata == 8'h00;
    endproperty
    a_unlock_rd: assert property (p_unlock_rd) else $error("unlock register read nonzero");
    property p_cp;
        @(posedge clock) disable iff (!rst_n)
            (ce && ext_rd && !code_protect_bit) |=> (ext_denied && ext_rdata == '0);
    endproperty
    a_cp: assert property (p_cp) else $error("protected memory read by programmer");
    property p_wr_hold;
        @(posedge clock) disable iff (!rst_n)
            (ce && wr_bit && !op_done) |=> wr_bit;
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write start cleared early");
    property p_write_error_flag;
        @(posedge clock) disable iff (!por_n)
            $rose(write_error_flag) |-> $past(write_mark);
    endproperty
    a_write_error_flag: assert property (p_write_error_flag) else $error("write error flag set with no write");

endmodule : fspc_ctrl

/* shared/fspc_params.svh */
// Purpose: constants of the flash self-program controller
// Assumes: 125 MHz core clock
// Notes:   included by the package, the software model and the bench
`ifndef FSPC_PARAMS_SVH
`define FSPC_PARAMS_SVH

`define FSPC_ADDR_W         15
`define FSPC_DATA_W         14
`define FSPC_ROW_BITS       5
`define FSPC_ROW_WORDS      32
`define FSPC_ERASED_WORD    14'h3fff
`define FSPC_MEM_WORDS      32768

// control register bit positions
`define FSPC_CTRL_RD        0
`define FSPC_CTRL_WR        1
`define FSPC_CTRL_WRITE_ENABLE_BIT      2
`define FSPC_CTRL_WRITE_ERROR_FLAG     3
`define FSPC_CTRL_ERASE     4
`define FSPC_CTRL_LATCH     5

// unlock pattern
`define FSPC_KEY1           8'h55
`define FSPC_KEY2           8'haa

// write protect limits (first unprotected address)
`define FSPC_WRT_LOW_LIMIT  15'h0800
`define FSPC_WRT_HALF_LIMIT 15'h4000
`define FSPC_WRT_OFF        2'h3
`define FSPC_WRT_LOW        2'h2
`define FSPC_WRT_HALF       2'h1

// self-timed write or erase
`define FSPC_CLOCK_PERIOD_NS 8
`define FSPC_WRITE_TIME_NS   2000
`define FSPC_WRITE_CYCLES    ((`FSPC_WRITE_TIME_NS + `FSPC_CLOCK_PERIOD_NS - 1) / `FSPC_CLOCK_PERIOD_NS)
`define FSPC_TIMER_W         16

`endif

/* shared/fspc_pkg.sv */
// Purpose: types of the flash self-program controller
// Assumes: fspc_params.svh holds the numbers
// Notes:   register select codes follow declaration order
`include "fspc_params.svh"

package fspc_pkg;
    typedef logic [`FSPC_ADDR_W-1:0] fspc_addr_t;
    typedef logic [`FSPC_DATA_W-1:0] fspc_word_t;
    typedef enum logic [2:0] {
        FSPC_SEL_ADDR_LOW,
        FSPC_SEL_ADDR_HIGH,
        FSPC_SEL_DATA_LOW,
        FSPC_SEL_DATA_HIGH,
        FSPC_SEL_CONTROL,
        FSPC_SEL_UNLOCK
    } fspc_sel_e;
    typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_KEY2} fspc_unlock_e;
    typedef enum logic [1:0] {OP_IDLE, OP_LATCH, OP_ERASE, OP_PROGRAM} fspc_op_e;
endpackage : fspc_pkg

/* tb/fspc_sw_model.sv */
// Purpose: core software side, issues register accesses to the controller
// Assumes: one access per wr_reg or rd_reg call, an idle cycle between calls
// Notes:   write data is scrambled once the strobe is released
`timescale 1ns/1ps
`include "fspc_params.svh"
module fspc_sw_model
    import fspc_pkg::*;
(
    // clock
    input  wire logic       clock,
    // register strobes
    output fspc_sel_e       sfr_sel,
    output logic            sfr_wr,
    output logic            sfr_rd,
    output logic [7:0]      sfr_wdata,
    input  wire logic [7:0] sfr_rdata
);
    initial
    begin
        sfr_sel   = FSPC_SEL_CONTROL;
        sfr_wr    = 1'b0;
        sfr_rd    = 1'b0;
        sfr_wdata = 8'h00;
    end

    task automatic wr_reg(input fspc_sel_e s, input logic [7:0] d);
        @(posedge clock);
        sfr_sel   <= s;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge clock);
        sfr_wr    <= 1'b0;
        sfr_wdata <= ~d;
    endtask : wr_reg

    task automatic rd_reg(input fspc_sel_e s, output logic [7:0] d);
        @(posedge clock);
        sfr_sel <= s;
        sfr_rd  <= 1'b1;
        @(posedge clock);
        sfr_rd  <= 1'b0;
        #1 d = sfr_rdata;
    endtask : rd_reg

    // keys then start, nothing else in between
    task automatic unlock_go(input logic [7:0] ctl);
        wr_reg(FSPC_SEL_UNLOCK, `FSPC_KEY1);
        wr_reg(FSPC_SEL_UNLOCK, `FSPC_KEY2);
        wr_reg(FSPC_SEL_CONTROL, ctl);
    endtask : unlock_go
endmodule : fspc_sw_model

/* tb/tb.sv */
// Purpose: self-checking bench of the flash self-program controller
// Assumes: 125 MHz clock, write time from the shared constants
// Notes:   programmer strobes are driven here, core side by the model
`timescale 1ns/1ps
`include "fspc_params.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb
    import fspc_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int WT = `FSPC_WRITE_CYCLES;
    logic       clock, rst_n, por_n, ce, busy, code_protect_bit, ext_denied;
    logic       ext_rd, ext_wr, ext_cfg_wr, ext_id_wr, ext_bulk_erase, ext_cfg_cp;
    logic [1:0] write_protect_field, ext_cfg_wrt;
    fspc_sel_e  sfr_sel;
    logic       sfr_wr, sfr_rd;
    logic [7:0] sfr_wdata, sfr_rdata, rv;
    fspc_addr_t ext_addr;
    fspc_word_t ext_wdata, ext_rdata;
    int         err_total, n_compared;
    fspc_addr_t lim [3] = '{15'h7fff, `FSPC_WRT_HALF_LIMIT, `FSPC_WRT_LOW_LIMIT};

    fspc_ctrl u_fspc_ctrl (
        .clock(clock), .rst_n(rst_n), .por_n(por_n), .ce(ce),
        .sfr_sel(sfr_sel), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .code_protect_bit(code_protect_bit),
        .write_protect_field(write_protect_field), .busy(busy),
        .ext_rd(ext_rd), .ext_wr(ext_wr), .ext_cfg_wr(ext_cfg_wr), .ext_id_wr(ext_id_wr),
        .ext_bulk_erase(ext_bulk_erase), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
        .ext_cfg_cp(ext_cfg_cp), .ext_cfg_wrt(ext_cfg_wrt), .ext_rdata(ext_rdata),
        .ext_denied(ext_denied)
    );
    fspc_sw_model u_fspc_sw_model (
        .clock(clock), .sfr_sel(sfr_sel), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata)
    );

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic report_and_stop;
        if (err_total == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    // counts cycles with busy high, bounded
    task automatic wait_done(input int exp_n);
        int n;
        n = 0;
        repeat (400)
        begin
            @(posedge clock);
            #1;
            if (busy !== 1'b1)
                break;
            n++;
        end
        if (n == 400)
        begin
            err_total++;
            $display("[ERR] %0t busy stuck", $time);
            report_and_stop();
        end
        else if (exp_n == 0)
            `CHK(n, 0)
        else if (exp_n > 0)
            `CHK(n, exp_n - 1)
    endtask : wait_done

    task automatic run_op(input logic [7:0] ctl, input int exp_n);
        u_fspc_sw_model.unlock_go(ctl);
        wait_done(exp_n);
    endtask : run_op

    task automatic set_addr(input fspc_addr_t a);
        u_fspc_sw_model.wr_reg(FSPC_SEL_ADDR_LOW, a[7:0]);
        u_fspc_sw_model.wr_reg(FSPC_SEL_ADDR_HIGH, {1'b0, a[14:8]});
    endtask : set_addr

    // latch one word, then program its row
    task automatic prog(input fspc_addr_t a, input fspc_word_t d, input int exp_n);
        set_addr(a);
        u_fspc_sw_model.wr_reg(FSPC_SEL_DATA_LOW, d[7:0]);
        u_fspc_sw_model.wr_reg(FSPC_SEL_DATA_HIGH, {2'b00, d[13:8]});
        run_op(8'h26, -1);
        run_op(8'h06, exp_n);
    endtask : prog

    task automatic sw_word(input fspc_addr_t a, input fspc_word_t e);
        logic [7:0] lo;
        logic [7:0] hi;
        set_addr(a);
        u_fspc_sw_model.wr_reg(FSPC_SEL_CONTROL, 8'h01);
        @(posedge clock);
        u_fspc_sw_model.rd_reg(FSPC_SEL_CONTROL, rv);
        `CHK(rv[0], 1'b0)
        u_fspc_sw_model.rd_reg(FSPC_SEL_DATA_LOW, lo);
        u_fspc_sw_model.rd_reg(FSPC_SEL_DATA_HIGH, hi);
        `CHK({hi[5:0], lo}, e)
    endtask : sw_word

    task automatic ext_chk(input fspc_addr_t a, input fspc_word_t e, input logic den);
        @(posedge clock);
        ext_addr <= a;
        ext_rd   <= 1'b1;
        @(posedge clock);
        ext_rd   <= 1'b0;
        #1;
        `CHK(ext_rdata, e)
        `CHK(ext_denied, den)
    endtask : ext_chk

    task automatic ext_cmd(input logic bulk, input logic cp, input logic [1:0] wrt);
        @(posedge clock);
        ext_cfg_cp     <= cp;
        ext_cfg_wrt    <= wrt;
        ext_bulk_erase <= bulk;
        ext_cfg_wr     <= ~bulk;
        @(posedge clock);
        ext_bulk_erase <= 1'b0;
        ext_cfg_wr     <= 1'b0;
        @(posedge clock);
        #1;
    endtask : ext_cmd

    initial
    begin
        err_total = 0;
        n_compared = 0;
        {rst_n, por_n, ext_rd, ext_wr, ext_cfg_wr, ext_id_wr, ext_bulk_erase} = '0;
        {ce, ext_cfg_cp, ext_cfg_wrt, ext_addr, ext_wdata} = {4'hf, 29'h0};
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        ext_cmd(1'b1, 1'b1, 2'h3);
        `CHK({code_protect_bit, write_protect_field}, 3'h7)
        u_fspc_sw_model.rd_reg(FSPC_SEL_CONTROL, rv);
        `CHK(rv, 8'h00)
        u_fspc_sw_model.wr_reg(FSPC_SEL_UNLOCK, 8'hff);
        u_fspc_sw_model.rd_reg(FSPC_SEL_UNLOCK, rv);
        `CHK(rv, 8'h00)
        u_fspc_sw_model.wr_reg(FSPC_SEL_ADDR_HIGH, 8'hff);
        u_fspc_sw_model.rd_reg(FSPC_SEL_ADDR_HIGH, rv);
        `CHK(rv, 8'h7f)
        u_fspc_sw_model.wr_reg(FSPC_SEL_DATA_HIGH, 8'hff);
        u_fspc_sw_model.rd_reg(FSPC_SEL_DATA_HIGH, rv);
        `CHK(rv, 8'h3f)
        prog(15'h0100, 14'h1234, WT);
        sw_word(15'h0100, 14'h1234);
        ext_chk(15'h0100, 14'h1234, 1'b0);
        prog(15'h0120, 14'h2a5a, WT);
        prog(15'h0120, 14'h0ff0, WT);
        ext_chk(15'h0120, 14'h0a50, 1'b0);
        set_addr(15'h011f);
        run_op(8'h16, WT);
        ext_chk(15'h0100, `FSPC_ERASED_WORD, 1'b0);
        ext_chk(15'h0120, 14'h0a50, 1'b0);
        set_addr(15'h0100);
        u_fspc_sw_model.wr_reg(FSPC_SEL_CONTROL, 8'h06);
        wait_done(0);
        u_fspc_sw_model.wr_reg(FSPC_SEL_UNLOCK, `FSPC_KEY1);
        u_fspc_sw_model.rd_reg(FSPC_SEL_ADDR_LOW, rv);
        u_fspc_sw_model.wr_reg(FSPC_SEL_UNLOCK, `FSPC_KEY2);
        u_fspc_sw_model.wr_reg(FSPC_SEL_CONTROL, 8'h06);
        wait_done(0);
        u_fspc_sw_model.wr_reg(FSPC_SEL_CONTROL, 8'h00);
        run_op(8'h02, 0);
        set_addr(15'h0101);
        u_fspc_sw_model.wr_reg(FSPC_SEL_CONTROL, 8'h26);
        set_addr(15'h0100);
        run_op(8'h06, WT);
        ext_chk(15'h0101, `FSPC_ERASED_WORD, 1'b0);
        ext_chk(15'h0100, 14'h0ff0, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            ext_cmd(1'b0, 1'b1, i[1:0]);
            prog(lim[i] - 15'h1, 14'h0000, 0);
            prog(lim[i], 14'h0155, (i > 0) ? WT : 0);
            ext_chk(lim[i] - 15'h1, `FSPC_ERASED_WORD, 1'b0);
        end
        ext_cmd(1'b0, 1'b0, 2'h3);
        `CHK(code_protect_bit, 1'b0)
        ext_chk(15'h0800, 14'h0000, 1'b1);
        @(posedge clock);
        ext_wr <= 1'b1;
        @(posedge clock);
        ext_wr <= 1'b0;
        #1;
        `CHK(ext_denied, 1'b1)
        sw_word(15'h0800, 14'h0155);
        prog(15'h0040, 14'h0007, WT);
        ext_cmd(1'b0, 1'b1, 2'h3);
        `CHK(code_protect_bit, 1'b0)
        ext_cmd(1'b1, 1'b1, 2'h3);
        `CHK(code_protect_bit, 1'b1)
        ext_chk(15'h0800, `FSPC_ERASED_WORD, 1'b0);
        set_addr(15'h0200);
        u_fspc_sw_model.unlock_go(8'h06);
        repeat (20) @(posedge clock);
        rst_n <= 1'b0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        u_fspc_sw_model.rd_reg(FSPC_SEL_CONTROL, rv);
        `CHK(rv, 8'h08)
        report_and_stop();
    end
endmodule : tb
